/* File: inc/ssp_if.sv */
`timescale 1ns/1ps
interface ssp_if;
   import ssp_pkg::*;
   logic clk_pin;
   logic dat_pin;
   logic tx_run;
   logic rx_run;
   logic tx_nine;
   logic rx_nine;
   logic tx_load;
   logic [CHAR_W-1:0] tx_word;
   logic tx_busy;
   logic tx_done;
   logic rx_done;
   logic [CHAR_W-1:0] rx_word;
   logic dat_out;
   logic dat_oe;

   modport ctl (output clk_pin, dat_pin, tx_run, rx_run, tx_nine, rx_nine, tx_load, tx_word,
                input tx_busy, tx_done, rx_done, rx_word, dat_out, dat_oe);
   modport shf (input clk_pin, dat_pin, tx_run, rx_run, tx_nine, rx_nine, tx_load, tx_word,
                output tx_busy, tx_done, rx_done, rx_word, dat_out, dat_oe);
endinterface

/* File: inc/ssp_pkg.sv */
package ssp_pkg;

   // ----------------------------------------
   // sizes
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int CHAR_W = 9;
   localparam int FIFO_DEPTH = 2;
   localparam int ADDR_W = 3;
   localparam logic [3:0] LEN_EIGHT = 4'h8;
   localparam logic [3:0] LEN_NINE = 4'h9;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [2:0] ADDR_IRQ_EN = 3'h0;
   localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h1;
   localparam logic [2:0] ADDR_RX_CTL = 3'h2;
   localparam logic [2:0] ADDR_TX_DATA = 3'h3;
   localparam logic [2:0] ADDR_TX_CTL = 3'h4;
   localparam logic [2:0] ADDR_RX_DATA = 3'h5;
   localparam logic [2:0] ADDR_IRQ_CTL = 3'h6;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int TCS_CLK_MASTER = 7;
   localparam int TCS_NINE = 6;
   localparam int TCS_TX_EN = 5;
   localparam int TCS_SYNC_MODE = 4;
   localparam int TCS_HIGH_RATE = 2;
   localparam int TCS_SHIFTER_EMPTY = 1;
   localparam int TCS_NINTH = 0;
   localparam int RCS_PORT_EN = 7;
   localparam int RCS_NINE = 6;
   localparam int RCS_SINGLE = 5;
   localparam int RCS_CONT = 4;
   localparam int RCS_ADDR_DET = 3;
   localparam int RCS_OVERRUN = 1;
   localparam int RCS_NINTH = 0;
   localparam int IEN_RX = 5;
   localparam int IEN_TX = 4;
   localparam int FLG_RX = 5;
   localparam int FLG_TX = 4;
   localparam int ICTL_GLOBAL = 7;
   localparam int ICTL_PERIPH = 6;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [7:0] IRQ_EN_RST = 8'h00;
   localparam logic [7:0] TX_CTL_RST = 8'h02;
   localparam logic [7:0] RX_CTL_RST = 8'h00;
   localparam logic [7:0] IRQ_CTL_RST = 8'h00;
   localparam logic [7:0] DATA_RST = 8'h00;

   typedef enum logic {TX_IDLE = 1'b0, TX_SHIFT = 1'b1} ssp_tx_e;

endpackage

/* File: logic/ssp_shifter.sv */
`timescale 1ns/1ps
module ssp_shifter import ssp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // link to the register side
   ssp_if.shf lnk
);

   function automatic logic [3:0] char_len(input logic nine);
      char_len = nine ? LEN_NINE : LEN_EIGHT;
   endfunction

   typedef struct packed {
      logic [1:0] ck_sync;
      logic [1:0] dt_sync;
      logic ck_prev;
      ssp_tx_e tx_st;
      logic [CHAR_W-1:0] tx_sh;
      logic [3:0] tx_cnt;
      logic dat_out;
      logic tx_done;
      logic [CHAR_W-1:0] rx_sh;
      logic [3:0] rx_cnt;
      logic rx_done;
      logic [CHAR_W-1:0] rx_word;
   } ssp_shf_s;

   ssp_shf_s q;
   ssp_shf_s d;
   logic rise;
   logic fall;

   // shifting advances only on edges seen on the external clock pin
   assign rise = q.ck_sync[1] & ~q.ck_prev;
   assign fall = ~q.ck_sync[1] & q.ck_prev;

   always_comb begin
      d = q;
      d.ck_sync = {q.ck_sync[0], lnk.clk_pin};
      d.dt_sync = {q.dt_sync[0], lnk.dat_pin};
      d.ck_prev = q.ck_sync[1];
      d.tx_done = 1'b0;
      d.rx_done = 1'b0;
      unique case (q.tx_st)
         TX_IDLE: begin
            if (lnk.tx_load) begin
               d.tx_st = TX_SHIFT;
               d.tx_sh = lnk.tx_word;
               d.tx_cnt = 4'h0;
            end
         end
         TX_SHIFT: begin
            if (lnk.tx_run) begin
               // new bit goes out on the leading edge, master samples on the trailing one
               if (rise) begin
                  d.dat_out = q.tx_sh[0];
               end
               if (fall) begin
                  d.tx_sh = q.tx_sh >> 1;
                  d.tx_cnt = q.tx_cnt + 4'h1;
                  if (q.tx_cnt == char_len(lnk.tx_nine) - 4'h1) begin
                     d.tx_st = TX_IDLE;
                     d.tx_done = 1'b1;
                  end
               end
            end
         end
      endcase
      // a dropped receive enable throws away the partial character
      if (!lnk.rx_run) begin
         d.rx_cnt = 4'h0;
      end else if (fall) begin
         d.rx_sh = lnk.rx_nine ? {q.dt_sync[1], q.rx_sh[8:1]} : {1'b0, q.dt_sync[1], q.rx_sh[7:1]};
         if (q.rx_cnt == char_len(lnk.rx_nine) - 4'h1) begin
            d.rx_cnt = 4'h0;
            d.rx_done = 1'b1;
            d.rx_word = d.rx_sh;
         end else begin
            d.rx_cnt = q.rx_cnt + 4'h1;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign lnk.tx_busy = (q.tx_st == TX_SHIFT);
   assign lnk.tx_done = q.tx_done;
   assign lnk.rx_done = q.rx_done;
   assign lnk.rx_word = q.rx_word;
   assign lnk.dat_out = q.dat_out;
   assign lnk.dat_oe = lnk.tx_run;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   a_data_on_lead: assert property ($changed(q.dat_out) |-> $past(rise))
      else $error("data pin changed away from a leading edge");

   a_tx_bit_count: assert property (q.tx_done |-> $past(q.tx_cnt) == char_len($past(lnk.tx_nine)) - 4'h1)
      else $error("transmit character ended at the wrong bit count");

   a_rx_pin_edges: assert property (($changed(q.rx_cnt) && $past(lnk.rx_run)) |-> $past(fall))
      else $error("receive count moved without a shift clock edge");

endmodule // ssp_shifter

/* File: logic/ssp_top.sv */
`timescale 1ns/1ps
module ssp_top import ssp_pkg::*; (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstn,
   // register port
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   // shift clock pin
   input wire logic shift_clock_pin_i,
   output logic shift_clock_pin_o,
   output logic shift_clock_pin_oe,
   // data pin
   input wire logic data_pin_i,
   output logic data_pin_o,
   output logic data_pin_oe,
   // core sleep and interrupt
   output logic wake_req,
   output logic irq_req
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic [DATA_W-1:0] irq_en;
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic clock_source_master;
      logic tx_nine_bit_select;
      logic transmit_enable;
      logic sync_mode;
      logic high_rate;
      logic tx_ninth_bit;
      logic port_enable;
      logic rx_nine_bit_select;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic address_detect_enable;
      logic overrun_error;
      logic [CHAR_W-1:0] hold;
      logic hold_full;
      logic [FIFO_DEPTH-1:0][CHAR_W-1:0] fifo;
      logic rd_ptr;
      logic [1:0] count;
      logic [DATA_W-1:0] rdata;
   } ssp_top_s;

   ssp_top_s q;
   ssp_top_s d;
   ssp_if lnk ();

   logic slave_mode;
   logic rx_mode;
   logic tx_run;
   logic rx_run;
   logic wr_tx;
   logic rd_rx;
   logic tx_load;
   logic tx_buffer_empty_flag;
   logic rx_complete_flag;
   logic [CHAR_W-1:0] head;
   logic pop;
   logic push;
   logic overflow;
   logic wr_idx;

   // ----------------------------------------
   // mode decode
   // ----------------------------------------
   // only slave mode is built, so the pin clock keeps running the shifters in sleep too
   assign slave_mode = q.port_enable & q.sync_mode & ~q.clock_source_master;
   assign rx_mode = q.continuous_receive_enable | q.single_receive_enable;
   assign tx_run = slave_mode & q.transmit_enable & ~rx_mode;
   // single receive is a don't care here; overrun freezes the receiver
   assign rx_run = slave_mode & q.continuous_receive_enable & ~q.overrun_error;

   assign wr_tx = reg_wr & (reg_addr == ADDR_TX_DATA);
   assign rd_rx = reg_rd & (reg_addr == ADDR_RX_DATA);

   // ----------------------------------------
   // transmit side
   // ----------------------------------------
   assign tx_load = q.hold_full & ~lnk.tx_busy & tx_run;
   assign tx_buffer_empty_flag = ~q.hold_full;

   // ----------------------------------------
   // receive fifo
   // ----------------------------------------
   assign head = q.fifo[q.rd_ptr];
   assign rx_complete_flag = (q.count != 2'h0);
   assign pop = rd_rx & rx_complete_flag;
   // a read in the same cycle frees a slot, so a full fifo can still take the character
   assign push = lnk.rx_done & ((q.count != 2'(FIFO_DEPTH)) | pop);
   assign overflow = lnk.rx_done & ~push;
   assign wr_idx = q.rd_ptr ^ q.count[0];

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      d = q;
      d.rdata = DATA_RST;
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_IRQ_EN: d.irq_en = reg_wdata;
            ADDR_IRQ_CTL: begin
               d.global_irq_enable = reg_wdata[ICTL_GLOBAL];
               d.peripheral_irq_enable = reg_wdata[ICTL_PERIPH];
            end
            ADDR_TX_CTL: begin
               d.clock_source_master = reg_wdata[TCS_CLK_MASTER];
               d.tx_nine_bit_select = reg_wdata[TCS_NINE];
               d.transmit_enable = reg_wdata[TCS_TX_EN];
               d.sync_mode = reg_wdata[TCS_SYNC_MODE];
               d.high_rate = reg_wdata[TCS_HIGH_RATE];
               d.tx_ninth_bit = reg_wdata[TCS_NINTH];
            end
            ADDR_RX_CTL: begin
               d.port_enable = reg_wdata[RCS_PORT_EN];
               d.rx_nine_bit_select = reg_wdata[RCS_NINE];
               d.single_receive_enable = reg_wdata[RCS_SINGLE];
               d.continuous_receive_enable = reg_wdata[RCS_CONT];
               d.address_detect_enable = reg_wdata[RCS_ADDR_DET];
            end
            // the ninth bit is taken as it stands at the moment of the byte write
            ADDR_TX_DATA: d.hold = {q.tx_ninth_bit, reg_wdata};
            default: ;
         endcase
      end
      // a write in the load cycle lands behind the character leaving the buffer
      d.hold_full = (q.hold_full & ~tx_load) | wr_tx;
      if (push) begin
         d.fifo[wr_idx] = lnk.rx_word;
      end
      if (pop) begin
         d.rd_ptr = ~q.rd_ptr;
      end
      d.count = q.count + {1'b0, push} - {1'b0, pop};
      // a fresh overrun wins over a clear in the same cycle
      d.overrun_error = overflow | (q.overrun_error & d.continuous_receive_enable);
      if (reg_rd) begin
         unique case (reg_addr)
            ADDR_IRQ_EN: d.rdata = q.irq_en;
            ADDR_IRQ_FLAGS: begin
               d.rdata[FLG_RX] = rx_complete_flag;
               d.rdata[FLG_TX] = tx_buffer_empty_flag;
            end
            ADDR_IRQ_CTL: begin
               d.rdata[ICTL_GLOBAL] = q.global_irq_enable;
               d.rdata[ICTL_PERIPH] = q.peripheral_irq_enable;
            end
            ADDR_TX_CTL: begin
               d.rdata[TCS_CLK_MASTER] = q.clock_source_master;
               d.rdata[TCS_NINE] = q.tx_nine_bit_select;
               d.rdata[TCS_TX_EN] = q.transmit_enable;
               d.rdata[TCS_SYNC_MODE] = q.sync_mode;
               d.rdata[TCS_HIGH_RATE] = q.high_rate;
               d.rdata[TCS_SHIFTER_EMPTY] = ~lnk.tx_busy;
               d.rdata[TCS_NINTH] = q.tx_ninth_bit;
            end
            ADDR_RX_CTL: begin
               d.rdata[RCS_PORT_EN] = q.port_enable;
               d.rdata[RCS_NINE] = q.rx_nine_bit_select;
               d.rdata[RCS_SINGLE] = q.single_receive_enable;
               d.rdata[RCS_CONT] = q.continuous_receive_enable;
               d.rdata[RCS_ADDR_DET] = q.address_detect_enable;
               d.rdata[RCS_OVERRUN] = q.overrun_error;
               d.rdata[RCS_NINTH] = head[CHAR_W-1];
            end
            ADDR_RX_DATA: d.rdata = head[DATA_W-1:0];
            default: d.rdata = DATA_RST;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!rstn) begin
         q <= '0;
         q.irq_en <= IRQ_EN_RST;
         q.global_irq_enable <= IRQ_CTL_RST[ICTL_GLOBAL];
         q.peripheral_irq_enable <= IRQ_CTL_RST[ICTL_PERIPH];
         q.clock_source_master <= TX_CTL_RST[TCS_CLK_MASTER];
         q.tx_nine_bit_select <= TX_CTL_RST[TCS_NINE];
         q.transmit_enable <= TX_CTL_RST[TCS_TX_EN];
         q.sync_mode <= TX_CTL_RST[TCS_SYNC_MODE];
         q.high_rate <= TX_CTL_RST[TCS_HIGH_RATE];
         q.tx_ninth_bit <= TX_CTL_RST[TCS_NINTH];
         q.port_enable <= RX_CTL_RST[RCS_PORT_EN];
         q.continuous_receive_enable <= RX_CTL_RST[RCS_CONT];
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------
   // shifter and pins
   // ----------------------------------------
   assign lnk.clk_pin = shift_clock_pin_i;
   assign lnk.dat_pin = data_pin_i;
   assign lnk.tx_run = tx_run;
   assign lnk.rx_run = rx_run;
   assign lnk.tx_nine = q.tx_nine_bit_select;
   assign lnk.rx_nine = q.rx_nine_bit_select;
   assign lnk.tx_load = tx_load;
   assign lnk.tx_word = q.hold;

   ssp_shifter u_shifter (
      .sys_clk (sys_clk),
      .rstn (rstn),
      .lnk (lnk.shf)
   );

   // the clock always comes from the master, so its driver stays off
   assign shift_clock_pin_o = 1'b0;
   assign shift_clock_pin_oe = 1'b0;
   assign data_pin_o = lnk.dat_out;
   assign data_pin_oe = lnk.dat_oe;
   assign reg_rdata = q.rdata;

   // ----------------------------------------
   // wake and interrupt
   // ----------------------------------------
   // wake needs no global enable: the core resumes even with interrupts masked
   assign wake_req = q.peripheral_irq_enable &
                     ((tx_buffer_empty_flag & q.irq_en[IEN_TX]) | (rx_complete_flag & q.irq_en[IEN_RX]));
   assign irq_req = q.global_irq_enable & wake_req;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   sequence s_idle_loaded;
      q.hold_full && !lnk.tx_busy && tx_run && !wr_tx;
   endsequence

   // a write in the done cycle refills the buffer, so it is kept out of both steps
   sequence s_held_behind_done;
      (lnk.tx_done && q.hold_full && tx_run && !wr_tx) ##1 (tx_run && !wr_tx);
   endsequence

   sequence s_third_char_full;
      lnk.rx_done && q.count == 2'h2 && !rd_rx;
   endsequence

   a_load_when_idle: assert property (s_idle_loaded |=> lnk.tx_busy && tx_buffer_empty_flag)
      else $error("idle shifter did not take the held character");

   a_hold_flag_low: assert property ((lnk.tx_busy && q.hold_full && !lnk.tx_done) |=> !tx_buffer_empty_flag)
      else $error("empty flag rose while a character was held");

   a_second_moves: assert property (s_held_behind_done |=> lnk.tx_busy && tx_buffer_empty_flag)
      else $error("held character did not follow the finished one");

   a_tx_wake: assert property ((tx_buffer_empty_flag && q.irq_en[IEN_TX] && q.peripheral_irq_enable) |-> wake_req)
      else $error("empty flag with enables set did not wake the core");

   a_rx_push: assert property ((lnk.rx_done && q.count == 2'h0) |=> rx_complete_flag && head == $past(lnk.rx_word))
      else $error("received character not placed at the fifo head");

   a_rx_irq: assert property (
      (rx_complete_flag && q.irq_en[IEN_RX] && q.peripheral_irq_enable && q.global_irq_enable)
      |-> irq_req && wake_req)
      else $error("receive flag with enables set raised no request");

   a_read_pops: assert property (
      (rd_rx && q.count == 2'h1 && !lnk.rx_done) |=> q.count == 2'h0 && reg_rdata == $past(head[DATA_W-1:0]))
      else $error("receive read did not return and drop the oldest byte");

   // the second cycle may legally see a read or a cleared continuous enable
   a_overrun_set: assert property (s_third_char_full |=>
      (q.overrun_error && q.count == 2'h2 && !rx_run) ##1
      ($past(rd_rx) || !$past(d.continuous_receive_enable) || (q.overrun_error && q.count == 2'h2 && !rx_run)))
      else $error("third character did not raise overrun and stop reception");

   a_overrun_clear: assert property ((q.overrun_error && !d.continuous_receive_enable && !lnk.rx_done)
      |=> !q.overrun_error)
      else $error("clearing continuous receive left overrun set");

   a_clock_driver_off: assert property (!shift_clock_pin_oe ##1 !shift_clock_pin_oe)
      else $error("clock pin driver was enabled");

   // ----------------------------------------
   // checks on registers, pins and the fifo
   // ----------------------------------------
   // read data is a one-cycle answer; anything lingering would look like a second read
   a_rdata_one_cycle: assert property (!$past(reg_rd) |-> reg_rdata == DATA_RST)
      else $error("read data stood outside the cycle after a read");

   a_tx_hold_word: assert property (wr_tx |=> q.hold == {$past(q.tx_ninth_bit), $past(reg_wdata)})
      else $error("transmit write did not capture ninth bit and low byte");

   a_write_fills: assert property (wr_tx |=> !tx_buffer_empty_flag)
      else $error("transmit write left the empty flag set");

   // a stopped transmitter parks the pin on its last bit instead of glitching it
   a_tx_pin_parked: assert property (!tx_run |=> $stable(data_pin_o))
      else $error("data pin moved while transmit was not running");

   // outside synchronous slave mode no pin edge may finish a character
   a_stopped_modes: assert property (!slave_mode |=> !lnk.rx_done && !lnk.tx_done)
      else $error("a character completed outside synchronous slave mode");

   a_flag_after_push: assert property ((lnk.rx_done && q.count != 2'(FIFO_DEPTH)) |=> rx_complete_flag)
      else $error("received character did not raise the receive flag");

   a_fifo_bound: assert property (q.count <= 2'(FIFO_DEPTH))
      else $error("fifo count went past its depth");

   a_wake_gated: assert property (!q.peripheral_irq_enable |-> !wake_req && !irq_req)
      else $error("wake or interrupt request without peripheral enable");

endmodule // ssp_top

/* File: verification/ssp_master_model.sv */
`timescale 1ns/1ps
module ssp_master_model (
   // link pins
   output logic sck,
   output logic m_dat,
   input wire logic dat_wire
);
   // ----------------------------------------
   // external synchronous master
   // ----------------------------------------
   initial begin
      sck = 1'b0;
      m_dat = 1'b0;
   end

   // clock stands still low outside frames, so the slave only ever sees whole characters
   task automatic shift(input logic [8:0] out, input int n, output logic [8:0] got);
      got = '0;
      #7;
      for (int i = 0; i < n; i++) begin
         sck = 1'b1;
         m_dat = out[i];
         #100;
         sck = 1'b0;
         got[i] = dat_wire;
         #100;
      end
      // a released line must not keep the last bit, or a stale sample could pass as good
      m_dat = ~m_dat;
   endtask
endmodule // ssp_master_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import ssp_pkg::*;
   // ----------------------------------------
   // signals
   // ----------------------------------------
   logic sys_clk;
   logic rstn;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata;
   logic [DATA_W-1:0] reg_rdata;
   logic reg_wr, reg_rd, sck, m_dat, dat_wire, sck_o, sck_oe, dat_o, dat_oe, wake_req, irq_req;
   logic [8:0] got;
   int errors, tests_run;
   // reset rows: index is the register address, value is what it should read
   logic [7:0] rst_exp [8] = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00};
   logic [8:0] ov [3] = '{9'h1a1, 9'h0b2, 9'h1c3};
   // rows: transmit control, receive control, flags expected after a character is clocked in
   logic [23:0] mode_rows [3] = '{24'h909010, 24'h009010, 24'h10a010};

   // the data wire is the device output while it drives, the master otherwise
   assign dat_wire = dat_oe ? dat_o : m_dat;

   ssp_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .shift_clock_pin_i(sck),
      .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .data_pin_i(dat_wire),
      .data_pin_o(dat_o), .data_pin_oe(dat_oe), .wake_req(wake_req), .irq_req(irq_req));
   ssp_master_model u_master (.sck(sck), .m_dat(m_dat), .dat_wire(dat_wire));

   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end

   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] seen);
      tests_run++;
      if (seen !== exp) begin
         errors++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rchk(input string what, input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk(what, {1'b0, exp}, {1'b0, reg_rdata});
   endtask
   task automatic settle;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask
   task automatic xfer(input logic [8:0] out, input int n);
      u_master.shift(out, n, got);
      repeat (8) @(posedge sys_clk);
   endtask
   task automatic summarize;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      errors = 0;
      tests_run = 0;
      repeat (16) @(posedge sys_clk);
      rstn <= 1'b1;
      wr(3'h7, 8'hff);
      for (int i = 0; i < 8; i++) rchk("reset value", 3'(i), rst_exp[i]);
      // transmit: two characters queued back to back
      wr(ADDR_IRQ_CTL, 8'h40);
      wr(ADDR_IRQ_EN, 8'h10);
      wr(ADDR_RX_CTL, 8'h80);
      wr(ADDR_TX_CTL, 8'h30);
      settle;
      chk("wake on empty buffer", 9'h001, {8'h00, wake_req});
      wr(ADDR_TX_DATA, 8'ha5);
      wr(ADDR_TX_DATA, 8'h3c);
      rchk("flags with held char", ADDR_IRQ_FLAGS, 8'h00);
      chk("wake while held", 9'h000, {8'h00, wake_req});
      chk("pin enables", 9'h001, {6'h00, sck_o, sck_oe, dat_oe});
      xfer(9'h000, 8);
      chk("first char", 9'h0a5, got);
      rchk("flags after first", ADDR_IRQ_FLAGS, 8'h10);
      chk("wake after first", 9'h001, {8'h00, wake_req});
      xfer(9'h000, 8);
      chk("second char", 9'h03c, got);
      wr(ADDR_TX_CTL, 8'h71);
      wr(ADDR_TX_DATA, 8'h5a);
      xfer(9'h000, 9);
      chk("nine bit char", 9'h15a, got);
      wr(ADDR_TX_CTL, 8'h10);
      settle;
      chk("driver off without enable", 9'h000, {8'h00, dat_oe});
      // receive
      wr(ADDR_IRQ_EN, 8'h20);
      wr(ADDR_RX_CTL, 8'h90);
      xfer(9'h096, 8);
      rchk("rx flag", ADDR_IRQ_FLAGS, 8'h30);
      chk("rx wake", 9'h002, {7'h00, wake_req, irq_req});
      wr(ADDR_IRQ_CTL, 8'hc0);
      settle;
      chk("rx irq", 9'h001, {8'h00, irq_req});
      rchk("rx byte", ADDR_RX_DATA, 8'h96);
      rchk("flags after pop", ADDR_IRQ_FLAGS, 8'h10);
      // clock master, asynchronous and single-receive-only settings must all leave the receiver idle
      foreach (mode_rows[i]) begin
         wr(ADDR_TX_CTL, mode_rows[i][23:16]);
         wr(ADDR_RX_CTL, mode_rows[i][15:8]);
         xfer(9'h0c7, 8);
         rchk("refused mode flags", ADDR_IRQ_FLAGS, mode_rows[i][7:0]);
      end
      // overrun with nine bit characters
      wr(ADDR_RX_CTL, 8'hd0);
      for (int i = 0; i < 3; i++) xfer(ov[i], 9);
      rchk("overrun set", ADDR_RX_CTL, 8'hd3);
      rchk("head kept", ADDR_RX_DATA, 8'ha1);
      rchk("second ninth", ADDR_RX_CTL, 8'hd2);
      rchk("second kept", ADDR_RX_DATA, 8'hb2);
      xfer(9'h1d4, 9);
      rchk("blocked in overrun", ADDR_IRQ_FLAGS, 8'h10);
      wr(ADDR_RX_CTL, 8'hc0);
      // with the fifo empty the ninth bit shows the stale slot that last held the first overrun character
      rchk("overrun cleared", ADDR_RX_CTL, 8'hc1);
      wr(ADDR_RX_CTL, 8'hd0);
      xfer(9'h0e4, 9);
      rchk("resumed ninth", ADDR_RX_CTL, 8'hd0);
      rchk("resumed byte", ADDR_RX_DATA, 8'he4);
      // mid-run reset: the data pin held a one from the nine-bit character and must drop
      @(posedge sys_clk);
      rstn <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rstn <= 1'b1;
      #1;
      chk("outputs after reset", 9'h000, {4'h0, dat_o, dat_oe, sck_oe, wake_req, irq_req});
      rchk("flags after reset", ADDR_IRQ_FLAGS, 8'h10);
      rchk("rx ctl after reset", ADDR_RX_CTL, 8'h00);
      summarize;
   end

   // whole run needs about 20 us of link traffic
   initial begin
      #200000;
      errors++;
      summarize;
   end
endmodule // testbench
